// *** shared/dac_pkg.sv ***
package dac_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CODE_W  = 14;
  localparam int ADDR_W  = 2;
  localparam int FRAME_W = 16;
  localparam int NUM_CH  = 2;

  // ----------------------------------------------------------------
  // preset codes and channel address decode
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] ZERO_CODE = 14'h0000;
  localparam logic [CODE_W-1:0] MID_CODE  = 14'h2000;

  localparam logic [ADDR_W-1:0] ADDR_NONE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_A    = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_B    = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_BOTH = 2'h3;

  // bit of each channel inside the address field
  localparam int CH_A = 0;
  localparam int CH_B = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_PERIOD_PS = 4000;
  localparam int POR_TIME_NS    = 20;
  localparam int POR_CYCLES     = (POR_TIME_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int POR_CNT_W      = 4;
  localparam logic [POR_CNT_W-1:0] POR_LOAD = POR_CNT_W'(POR_CYCLES);
  localparam logic [POR_CNT_W-1:0] POR_DONE = 4'h0;
  localparam logic [POR_CNT_W-1:0] POR_STEP = 4'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] code;
  } frame_t;

  typedef struct packed {
    logic scale;
    logic load_n;
    logic preset_n;
    logic cs_n;
  } pins_t;

  localparam int    PIN_W    = 4;
  localparam pins_t PIN_IDLE = 4'h7;

  typedef enum {ST_POR, ST_RUN} por_state_t;

endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire dac_pkg::pins_t      pins_raw,
  output dac_pkg::pins_t           pins
);
  import dac_pkg::*;

  pins_t s1;
  pins_t s2;
  pins_t s3;

  // ----------------------------------------------------------------
  // three stages; a change is taken once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1   <= PIN_IDLE;
      s2   <= PIN_IDLE;
      s3   <= PIN_IDLE;
      pins <= PIN_IDLE;
    end else begin
      s1 <= pins_raw;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < PIN_W; i++) begin
        if (s2[i] == s3[i]) begin
          pins[i] <= s3[i];
        end
      end
    end
  end

endmodule // pin_sync

// *** hdl/serial_shift.sv ***
`timescale 1ns/1ps
module serial_shift (
  input  wire logic                sclk,
  input  wire logic                rst,
  input  wire logic                cs_n,
  input  wire logic                serial_in,
  output dac_pkg::frame_t          word
);
  import dac_pkg::*;

  logic               rst_s1;
  logic               link_rst;
  logic [FRAME_W-1:0] sr;

  // ----------------------------------------------------------------
  // reset brought onto the serial clock; only acts while sclk runs
  // ----------------------------------------------------------------
  always_ff @(posedge sclk) begin
    rst_s1   <= rst;
    link_rst <= rst_s1;
  end

  // ----------------------------------------------------------------
  // shift register: 16 deep so only the last 16 bits survive
  // ----------------------------------------------------------------
  always_ff @(posedge sclk) begin
    if (link_rst) begin
      sr <= '0;
    end else if (!cs_n) begin
      sr <= {sr[FRAME_W-2:0], serial_in};
    end
  end

  assign word = frame_t'(sr);

  a_shift_hold: assert property (@(posedge sclk) disable iff (link_rst)
    cs_n |=> $stable(sr))
    else $error("shift register moved while chip select high");

  a_shift_in: assert property (@(posedge sclk) disable iff (link_rst)
    !cs_n |=> (sr[0] == $past(serial_in)) && (sr[FRAME_W-1:1] == $past(sr[FRAME_W-2:0])))
    else $error("serial bit not shifted straight in");

endmodule // serial_shift

// *** hdl/dual_dac_serial_load_logic.sv ***
`timescale 1ns/1ps
// Behaviour
// - two independent channels, each converting a 14-bit code from its converter register
// - serial input bit goes straight into the shift register
// - shift one bit per rising serial clock; host sets data for that edge
// - with chip select high, serial clock edges leave the shift register alone
// - chip select rising copies the shift register into the addressed input register
// - chip select never affects the input-to-converter transfer
// - load strobe low makes converter registers follow input registers
// - one load strobe updates both converter registers together
// - preset low forces all registers to 0x0000 or 0x2000 by scale pin
// - power-on presets all registers exactly like a preset pulse
// - frame is 16 bits, MSB first: two address bits then 14-bit code
// - only the last 16 bits shifted in are used at chip select rising
// - address 00 none, 01 channel A, 10 channel B, 11 both
module dual_dac_serial_load_logic (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    serial_in,
  input  wire logic                    preset_n,
  input  wire logic                    load_convert_regs_n,
  input  wire logic                    scale_sel,
  output logic [dac_pkg::CODE_W-1:0]   code_a,
  output logic [dac_pkg::CODE_W-1:0]   code_b
);
  import dac_pkg::*;

  // ----------------------------------------------------------------
  // link side: serial shift register on its own clock
  // ----------------------------------------------------------------
  frame_t word;

  serial_shift u_shift (
    .sclk      (sclk),
    .rst       (rst),
    .cs_n      (cs_n),
    .serial_in (serial_in),
    .word      (word)
  );

  // ----------------------------------------------------------------
  // control pins into the core clock
  // ----------------------------------------------------------------
  pins_t pins_raw;
  pins_t pins;

  assign pins_raw.cs_n     = cs_n;
  assign pins_raw.preset_n = preset_n;
  assign pins_raw.load_n   = load_convert_regs_n;
  assign pins_raw.scale    = scale_sel;

  pin_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pins_raw (pins_raw),
    .pins     (pins)
  );

  // ----------------------------------------------------------------
  // chip select edge and word capture
  // ----------------------------------------------------------------
  // the shift register is frozen while cs_n is high, so the word is
  // quasi-static by the time the synchronised rising edge appears;
  // cs_n high must outlast the synchroniser delay for this to hold
  logic   cs_prev;
  logic   cs_rise;
  frame_t frame;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= pins.cs_n;
    end
  end

  assign cs_rise = pins.cs_n & ~cs_prev;
  assign frame   = word;

  // ----------------------------------------------------------------
  // power-on preset sequencer
  // ----------------------------------------------------------------
  // holds the preset a few cycles past reset so the scale pin has
  // come through its synchroniser before it is used
  por_state_t             state;
  por_state_t             next_state;
  logic [POR_CNT_W-1:0]   por_cnt;
  logic [POR_CNT_W-1:0]   next_por_cnt;

  always_comb begin
    next_state   = state;
    next_por_cnt = por_cnt;
    case (state)
      ST_POR: begin
        if (por_cnt == POR_DONE) begin
          next_state = ST_RUN;
        end else begin
          next_por_cnt = por_cnt - POR_STEP;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state   = ST_POR;
        next_por_cnt = POR_LOAD;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state   <= ST_POR;
      por_cnt <= POR_LOAD;
    end else begin
      state   <= next_state;
      por_cnt <= next_por_cnt;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire                    preset_active = (state == ST_POR) | ~pins.preset_n;
  wire [CODE_W-1:0]       preset_code   = pins.scale ? MID_CODE : ZERO_CODE;
  wire                    load_active   = ~pins.load_n & ~preset_active;
  wire                    write_ok      = cs_rise & ~preset_active;
  wire [NUM_CH-1:0]       ch_sel        = frame.addr;

  // ----------------------------------------------------------------
  // per-channel input and converter registers
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] inp  [NUM_CH];
  logic [CODE_W-1:0] conv [NUM_CH];

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    always_ff @(posedge core_clk) begin
      if (rst) begin
        inp[ch]  <= ZERO_CODE;
        conv[ch] <= ZERO_CODE;
      end else if (preset_active) begin
        inp[ch]  <= preset_code;
        conv[ch] <= preset_code;
      end else begin
        if (write_ok && ch_sel[ch]) begin
          inp[ch] <= frame.code;
        end
        // transfer keyed on the strobe alone, common to both channels
        if (load_active) begin
          conv[ch] <= inp[ch];
        end
      end
    end
  end

  assign code_a = conv[CH_A];
  assign code_b = conv[CH_B];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_preset_zero: assert property (@(posedge core_clk) disable iff (rst)
    (preset_active && !pins.scale) |=>
      (code_a == ZERO_CODE) && (code_b == ZERO_CODE) &&
      (inp[CH_A] == ZERO_CODE) && (inp[CH_B] == ZERO_CODE))
    else $error("zero-scale preset not applied");

  a_preset_mid: assert property (@(posedge core_clk) disable iff (rst)
    (preset_active && pins.scale) |=>
      (code_a == MID_CODE) && (code_b == MID_CODE) &&
      (inp[CH_A] == MID_CODE) && (inp[CH_B] == MID_CODE))
    else $error("midscale preset not applied");

  a_por_preset: assert property (@(posedge core_clk)
    $fell(rst) |-> (state == ST_POR) ##1 (state == ST_POR)[*4])
    else $error("power-on preset window too short");

  a_load_both: assert property (@(posedge core_clk) disable iff (rst)
    load_active |=> (code_a == $past(inp[CH_A])) && (code_b == $past(inp[CH_B])))
    else $error("converter registers did not follow input registers");

  a_latched_hold: assert property (@(posedge core_clk) disable iff (rst)
    (!load_active && !preset_active) |=> $stable(code_a) && $stable(code_b))
    else $error("converter register moved without load strobe");

  a_same_update: assert property (@(posedge core_clk) disable iff (rst)
    (!preset_active && ($changed(code_a) || $changed(code_b))) |->
      $past(load_active))
    else $error("channel update without a shared load strobe");

  a_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (write_ok && frame.addr == ADDR_A) |=>
      (inp[CH_A] == $past(frame.code)) && $stable(inp[CH_B]))
    else $error("write to channel A misrouted");

  a_write_b: assert property (@(posedge core_clk) disable iff (rst)
    (write_ok && frame.addr == ADDR_B) |=>
      (inp[CH_B] == $past(frame.code)) && $stable(inp[CH_A]))
    else $error("write to channel B misrouted");

  a_write_both: assert property (@(posedge core_clk) disable iff (rst)
    (write_ok && frame.addr == ADDR_BOTH) |=>
      (inp[CH_A] == $past(frame.code)) && (inp[CH_B] == $past(frame.code)))
    else $error("broadcast write missed a channel");

  a_write_none: assert property (@(posedge core_clk) disable iff (rst)
    (!preset_active && !write_ok) |=> $stable(inp[CH_A]) && $stable(inp[CH_B]))
    else $error("input register changed without a frame");

  a_addr_none: assert property (@(posedge core_clk) disable iff (rst)
    (write_ok && frame.addr == ADDR_NONE) |=>
      $stable(inp[CH_A]) && $stable(inp[CH_B]))
    else $error("null address wrote a channel");

  a_preset_wins: assert property (@(posedge core_clk) disable iff (rst)
    (preset_active && (cs_rise || !pins.load_n)) |=>
      (code_a == $past(preset_code)) && (inp[CH_B] == $past(preset_code)))
    else $error("preset lost priority");

endmodule // dual_dac_serial_load_logic

// *** verification/serial_host.sv ***
`timescale 1ns/1ps
module serial_host (
  output logic sclk,
  output logic cs_n,
  output logic serial_in
);
  // ----------------------------------------------------------------
  // link timing: 15 ns clock, still between frames unless stray_clocks runs it
  // ----------------------------------------------------------------
  localparam realtime HALF = 7.5;

  initial begin
    sclk      = 1'b0;
    cs_n      = 1'b1;
    serial_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame: data moves only while the clock is low, msb first
  // ----------------------------------------------------------------
  task automatic send(input int value, input int n);
    cs_n = 1'b0;
    #HALF;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = value[i];
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
    #HALF cs_n = 1'b1;
    // released line must not keep showing the last bit
    serial_in = ~serial_in;
    // select stays high well past the core's sync window
    #40;
  endtask

  // clock edges with select high, noisy data
  task automatic stray_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      serial_in = $urandom;
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
    #40;
  endtask
endmodule // serial_host

// *** verification/test_dual_dac_serial_load_logic.sv ***
`timescale 1ns/1ps
module test_dual_dac_serial_load_logic;
  import dac_pkg::*;
  logic              core_clk;
  logic              rst;
  logic              sclk;
  logic              cs_n;
  logic              serial_in;
  logic              preset_n;
  logic              load_convert_regs_n;
  logic              scale_sel;
  logic [CODE_W-1:0] code_a;
  logic [CODE_W-1:0] code_b;
  int                fails;
  int                n_tests;
  int                sr;
  int                addr;
  int                inp [2];
  int                conv [2];

  dual_dac_serial_load_logic i_dual_dac_serial_load_logic (
    .core_clk            (core_clk),
    .rst                 (rst),
    .sclk                (sclk),
    .cs_n                (cs_n),
    .serial_in           (serial_in),
    .preset_n            (preset_n),
    .load_convert_regs_n (load_convert_regs_n),
    .scale_sel           (scale_sel),
    .code_a              (code_a),
    .code_b              (code_b)
  );

  serial_host i_serial_host (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .serial_in (serial_in)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // checking and model
  // ----------------------------------------------------------------
  task automatic final_report();
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [CODE_W-1:0] seen, input int exp);
    n_tests++;
    if (seen !== CODE_W'(exp)) begin
      fails++;
      $display("BAD %0t code %h expected %h", $time, seen, CODE_W'(exp));
    end
  endtask

  // the model keeps its own 16-bit window of shifted bits
  task automatic frame(input int value, input int n);
    for (int i = n - 1; i >= 0; i--) sr = ((sr << 1) | value[i]) & 32'h0000_ffff;
    i_serial_host.send(value, n);
    if (preset_n) begin
      addr = sr >> 14;
      for (int c = 0; c < 2; c++) if (addr[c]) inp[c] = sr & 32'h0000_3fff;
    end
  endtask

  // wait beyond every sync latency, then compare both channels
  task automatic settle();
    repeat (12) @(posedge core_clk);
    for (int c = 0; c < 2; c++) begin
      if (!preset_n) begin
        inp[c]  = scale_sel ? 32'h0000_2000 : 32'h0000_0000;
        conv[c] = inp[c];
      end else if (!load_convert_regs_n) conv[c] = inp[c];
    end
    check(code_a, conv[0]);
    check(code_b, conv[1]);
  endtask

  initial begin
    #100000;
    fails++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(31));
    fails = 0;
    n_tests = 0;
    sr = 0;
    rst = 1'b1;
    preset_n = 1'b1;
    load_convert_regs_n = 1'b0;
    scale_sel = 1'b1;
    i_serial_host.stray_clocks(3);
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    // link reset leaves through two sclk flops: tick them with select high
    i_serial_host.stray_clocks(3);
    foreach (inp[c]) begin
      inp[c]  = 32'h0000_2000;
      conv[c] = inp[c];
    end
    settle();
    for (int a = 0; a < 4; a++) begin
      frame((a << 14) | ($urandom & 32'h0000_3fff), 16);
      settle();
    end
    frame($urandom, 24);
    settle();
    // a full frame sets known bits; the later 8-bit partial frame exposes any bit taken while select was high
    frame($urandom | 32'h0000_0040, 16);
    settle();
    i_serial_host.stray_clocks(8);
    frame($urandom, 8);
    settle();
    @(posedge core_clk) load_convert_regs_n <= 1'b1;
    settle();
    frame(32'h0000_c000 | ($urandom & 32'h0000_3fff), 16);
    settle();
    @(posedge core_clk) load_convert_regs_n <= 1'b0;
    settle();
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk) begin
        scale_sel <= s[0];
        preset_n  <= 1'b0;
      end
      frame(32'h0000_ffff, 16);
      settle();
      @(posedge core_clk) preset_n <= 1'b1;
      settle();
    end
    final_report();
  end
endmodule // test_dual_dac_serial_load_logic
